// ==== rpg_pkg.sv ====
// Purpose: Shared constants and types for the pulse gate and fault latch
// Assumes: 50 MHz ref_clk, APB register access
// Notes: Operation list below
// Operation
// - Pulse settings accepted only from the host serial command path
// - Frequency valid from 150 Hz to 50000 Hz, sets pulse period
// - Duty cycle valid from 10 to 90 percent
// - While pulsing, output on for duty percent of each period
// - Setting changes rejected while output is on
// - Valid frequency and duty via commands 93 and 96 enable pulsing
// - Invalid combination disables pulsing, output becomes steady
// - Read-back commands 193 and 196 return held frequency and duty
// - Settings volatile; every reset restores defaults
// - Over-temperature shutdown disables output, latches overtemp and alarm
// - Temperature warning flashes overtemp indicator, output unchanged
// - After interlock break, output and indicator off until restored and off command
// - Latched-off output flashes output-on indicator until cause clears and off
// - User mode request at power-up blocks output, flashes until off command
// - Any error-code fault lights the alarm indicator
// - Error code holds one active fault by priority: live overtemp, interlock, supply, timer, then latched overtemp; zero when none
// - Setpoint timer expiry shuts output off, error held until off command
package rpg_pkg;
  // =====================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  // =====================================================
  // Limits and defaults
  localparam logic [15:0] FREQ_MIN = 16'd150;
  localparam logic [15:0] FREQ_MAX = 16'd50000;
  localparam logic [7:0] DUTY_MIN = 8'd10;
  localparam logic [7:0] DUTY_MAX = 8'd90;
  localparam logic [15:0] FREQ_RST = 16'd1000;
  localparam logic [7:0] DUTY_RST = 8'd50;
  // =====================================================
  // Commands
  localparam logic [7:0] CMD_OFF = 8'h01;
  localparam logic [7:0] CMD_ON = 8'h02;
  localparam logic [7:0] CMD_SET_FREQ = 8'd93;
  localparam logic [7:0] CMD_SET_DUTY = 8'd96;
  localparam logic [7:0] CMD_GET_FREQ = 8'd193;
  localparam logic [7:0] CMD_GET_DUTY = 8'd196;
  // =====================================================
  // APB offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RESP = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_ERR = 8'h0c;
  localparam logic [7:0] OFS_TMR = 8'h10;
  // CMD register fields: [7:0] code, [23:8] argument
  localparam int CMD_ARG_LSB = 8;
  // =====================================================
  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_TIMER = 8'h01;
  localparam logic [7:0] ERR_OTEMP = 8'h04;
  localparam logic [7:0] ERR_ILOCK = 8'h10;
  localparam logic [7:0] ERR_SUPPLY = 8'h11;
  typedef struct packed {
    logic output_on;
    logic ovt;
    logic alarm;
    logic ilock;
    logic mains_present_indicator;
  } rpg_led_s;
  typedef enum logic [1:0] {ST_OFF = 2'b00, ST_ON = 2'b01, ST_LATCH = 2'b11} rpg_state_e;
endpackage

// ==== rpg_gate.sv ====
// Purpose: Output-enable pulse gate with fault and interlock latches
// Assumes: Fault inputs are asynchronous pins; APB on ref_clk
// Notes: Command register is the host serial path
module rpg_gate
  import rpg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic user_mode,
  input wire logic output_enable_request,
  input wire logic output_disable_request,
  input wire logic pin_ovt_shutdown,
  input wire logic pin_ovt_warning,
  input wire logic pin_interlock_ok,
  input wire logic pin_mains_ok,
  input wire logic pin_at_setpoint,
  output logic rf_gate,
  output rpg_led_s leds
);
  // =====================================================
  // Input synchronisers
  logic [6:0] sy1_q, sy2_q;
  always_ff @(posedge ref_clk)
  begin
    sy1_q <= {user_mode, output_enable_request, output_disable_request,
              pin_ovt_shutdown, pin_ovt_warning, pin_interlock_ok, pin_mains_ok};
    sy2_q <= sy1_q;
  end
  logic umode, uon, uoff, ovt_sd, ovt_w, ilk_ok, mains_ok, at_sp;
  logic sp1_q, sp2_q;
  always_ff @(posedge ref_clk)
  begin
    sp1_q <= pin_at_setpoint;
    sp2_q <= sp1_q;
  end
  assign {umode, uon, uoff, ovt_sd, ovt_w, ilk_ok, mains_ok} = sy2_q;
  assign at_sp = sp2_q;

  // =====================================================
  // APB decode
  logic wr, rd;
  // Zero wait states: every register answers in its access cycle
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  function automatic logic hit(input logic [7:0] a);
    hit = (a == OFS_CMD) || (a == OFS_RESP) || (a == OFS_STAT) || (a == OFS_ERR)
          || (a == OFS_TMR);
  endfunction
  assign pslverr = psel & penable & ~hit(paddr);
  logic cmd_wr;
  logic [7:0] code;
  logic [15:0] arg;
  assign cmd_wr = wr && paddr == OFS_CMD;
  assign code = pwdata[7:0];
  assign arg = pwdata[CMD_ARG_LSB +: 16];
  logic off_cmd, on_cmd;
  assign off_cmd = (cmd_wr && code == CMD_OFF) || (umode && uoff);
  assign on_cmd = (cmd_wr && code == CMD_ON && !umode) || (umode && uon);

  // =====================================================
  // Settings and control state
  logic [15:0] freq_q, freq_d;
  logic [7:0] duty_q, duty_d;
  logic fvalid_q, fvalid_d, dvalid_q, dvalid_d;
  logic [31:0] resp_q, resp_d;
  logic [31:0] tmr_q, tmr_d;
  rpg_state_e st_q, st_d;
  logic ovt_lat_q, ovt_lat_d, ilk_lat_q, ilk_lat_d, sup_lat_q, sup_lat_d;
  logic tmo_q, tmo_d, boot_q, boot_d, first_q, first_d;
  logic [7:0] err_q, err_d;
  logic [31:0] spc_q, spc_d;
  logic [25:0] per_q, per_d, ontm_q, ontm_d, pc_q, pc_d;
  logic [23:0] fl_q, fl_d;
  logic pulse_en;
  logic cause;
  assign pulse_en = fvalid_q & dvalid_q;
  // A live cause blocks both a start and a release
  assign cause = ovt_sd | ~ilk_ok | ~mains_ok;

  function automatic logic [25:0] per_of(input logic [15:0] f);
    per_of = 26'(CLK_HZ / 32'(f));
  endfunction

  // Shared by both setting checks; bounds are inclusive
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = v >= lo && v <= hi;
  endfunction

  always_comb
  begin
    freq_d = freq_q;
    duty_d = duty_q;
    fvalid_d = fvalid_q;
    dvalid_d = dvalid_q;
    resp_d = resp_q;
    tmr_d = tmr_q;
    if (cmd_wr && st_q != ST_ON)
    begin
      if (code == CMD_SET_FREQ)
      begin
        freq_d = arg;
        fvalid_d = in_range(arg, FREQ_MIN, FREQ_MAX);
      end
      if (code == CMD_SET_DUTY)
      begin
        duty_d = arg[7:0];
        dvalid_d = in_range(arg, 16'(DUTY_MIN), 16'(DUTY_MAX));
      end
    end
    if (cmd_wr && code == CMD_GET_FREQ)
      resp_d = {16'h0000, freq_q};
    if (cmd_wr && code == CMD_GET_DUTY)
      resp_d = {24'h000000, duty_q};
    if (wr && paddr == OFS_TMR)
      tmr_d = pwdata;
  end

  // =====================================================
  // Fault latches and output state
  always_comb
  begin
    ovt_lat_d = ovt_lat_q;
    ilk_lat_d = ilk_lat_q;
    sup_lat_d = sup_lat_q;
    tmo_d = tmo_q;
    boot_d = boot_q;
    first_d = 1'b0;
    st_d = st_q;
    spc_d = spc_q;
    if (!ovt_w && !ovt_sd)
      ovt_lat_d = 1'b0;
    if (off_cmd)
    begin
      boot_d = 1'b0;
      tmo_d = 1'b0;
      if (ilk_ok)
        ilk_lat_d = 1'b0;
      if (mains_ok)
        sup_lat_d = 1'b0;
    end
    // Power-up request outranks an off seen in the same cycle
    if (first_q && umode && uon)
      boot_d = 1'b1;
    if (ovt_sd)
      ovt_lat_d = 1'b1;
    if (!ilk_ok)
      ilk_lat_d = 1'b1;
    if (!mains_ok)
      sup_lat_d = 1'b1;
    // Timer runs only while on and short of setpoint
    spc_d = (st_q == ST_ON && !at_sp) ? spc_q + 32'd1 : 32'd0;
    if (tmr_q != 32'd0 && spc_q >= tmr_q)
      tmo_d = 1'b1;
    case (st_q)
      ST_OFF:
        if (on_cmd && !boot_d && !cause)
          st_d = ST_ON;
      ST_ON:
        if (off_cmd)
          st_d = ST_OFF;
        else if (ovt_lat_d || ilk_lat_d || sup_lat_d || tmo_d)
          st_d = ST_LATCH;
      ST_LATCH:
        if (off_cmd && !cause && !ovt_lat_d)
          st_d = ST_OFF;
      default:
        st_d = ST_OFF;
    endcase
    // A fault in this cycle beats a concurrent on command
    if (ilk_lat_d || sup_lat_d || ovt_lat_d || tmo_d)
      if (st_d == ST_ON)
        st_d = ST_LATCH;
  end

  always_comb
  begin
    err_d = ERR_NONE;
    if (tmo_q)
      err_d = ERR_TIMER;
    if (sup_lat_q)
      err_d = ERR_SUPPLY;
    if (ilk_lat_q)
      err_d = ERR_ILOCK;
    if (ovt_lat_q && ovt_sd)
      err_d = ERR_OTEMP;
    else if (ovt_lat_q && err_d == ERR_NONE)
      err_d = ERR_OTEMP;
  end

  // =====================================================
  // Pulse timing
  always_comb
  begin
    per_d = per_of(pulse_en ? freq_q : FREQ_RST);
    ontm_d = 26'((32'(per_d) * 32'(duty_q)) / 32'd100);
    pc_d = (st_q != ST_ON || pc_q + 26'd1 >= per_q) ? 26'd0 : pc_q + 26'd1;
    fl_d = (fl_q + 24'd1 >= 24'(FLASH_CYC)) ? 24'd0 : fl_q + 24'd1;
  end

  // Half-rate toggle keeps flash slow without a second counter
  logic blink_q, blink_d;
  assign blink_d = (fl_q == 24'd0) ? ~blink_q : blink_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      freq_q <= FREQ_RST;
      duty_q <= DUTY_RST;
      fvalid_q <= 1'b0;
      dvalid_q <= 1'b0;
      resp_q <= 32'h00000000;
      tmr_q <= 32'h00000000;
      st_q <= ST_OFF;
      ovt_lat_q <= 1'b0;
      ilk_lat_q <= 1'b0;
      sup_lat_q <= 1'b0;
      tmo_q <= 1'b0;
      boot_q <= 1'b0;
      first_q <= 1'b1;
      err_q <= ERR_NONE;
      spc_q <= 32'h00000000;
      per_q <= 26'h0000000;
      ontm_q <= 26'h0000000;
      pc_q <= 26'h0000000;
      fl_q <= 24'h000000;
      blink_q <= 1'b0;
    end
    else
    begin
      freq_q <= freq_d;
      duty_q <= duty_d;
      fvalid_q <= fvalid_d;
      dvalid_q <= dvalid_d;
      resp_q <= resp_d;
      tmr_q <= tmr_d;
      st_q <= st_d;
      ovt_lat_q <= ovt_lat_d;
      ilk_lat_q <= ilk_lat_d;
      sup_lat_q <= sup_lat_d;
      tmo_q <= tmo_d;
      boot_q <= boot_d;
      first_q <= first_d;
      err_q <= err_d;
      spc_q <= spc_d;
      per_q <= per_d;
      ontm_q <= ontm_d;
      pc_q <= pc_d;
      fl_q <= fl_d;
      blink_q <= blink_d;
    end
  end

  // =====================================================
  // Outputs
  logic gate_d, gate_q;
  rpg_led_s led_d, led_q;
  assign gate_d = (st_q == ST_ON) && (!pulse_en || pc_q < ontm_q);
  always_comb
  begin
    led_d.output_on = (st_q == ST_ON) | ((st_q == ST_LATCH || boot_q) & blink_q);
    // Latched shutdown shows solid until below warning; a warning alone flashes
    led_d.ovt = ovt_sd | ovt_lat_q | (ovt_w & blink_q);
    led_d.alarm = err_q != ERR_NONE;
    led_d.ilock = ilk_ok & ~ilk_lat_q;
    led_d.mains_present_indicator = mains_ok;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      gate_q <= 1'b0;
      led_q <= '0;
      prdata <= 32'h00000000;
    end
    else
    begin
      gate_q <= gate_d;
      led_q <= led_d;
      case (paddr)
        OFS_RESP: prdata <= resp_q;
        OFS_STAT: prdata <= {24'h000000, pulse_en, boot_q, tmo_q, sup_lat_q,
                             ilk_lat_q, ovt_lat_q, st_q};
        OFS_ERR: prdata <= {24'h000000, err_q};
        OFS_TMR: prdata <= tmr_q;
        default: prdata <= 32'h00000000;
      endcase
    end
  end
  assign rf_gate = gate_q;
  assign leds = led_q;
endmodule // rpg_gate

// ==== rpg_gate_assertions.sv ====
// Purpose: Port checker for the pulse gate
// Assumes: Two-flop input sync plus output register
// Notes: Bound to every rpg_gate instance
module rpg_gate_checker
  import rpg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pin_ovt_shutdown,
  input wire logic pin_interlock_ok,
  input wire logic pin_mains_ok,
  input wire logic rf_gate,
  input wire rpg_led_s leds
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Six samples cover sync, latch, error code and LED register
  rst_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !rf_gate && leds == '0)
    else $error("outputs not cleared by reset");
  ovt_shut_a: assert property (pin_ovt_shutdown [*6] |-> !rf_gate && leds.ovt && leds.alarm)
    else $error("overtemp did not shut output");
  mains_off_a: assert property (!pin_mains_ok [*6] |-> !rf_gate && leds.alarm)
    else $error("supply fault not latched");
  ilock_off_a: assert property (!pin_interlock_ok [*5] |-> !rf_gate && !leds.ilock)
    else $error("interlock break left output on");
  ilock_hold_a: assert property (!leds.ilock && !$past(leds.ilock) |-> !rf_gate)
    else $error("output on while interlock latched");
  ready_high_a: assert property (psel |-> pready)
    else $error("bus not ready");
  unmapped_err_a: assert property (psel && penable && paddr > OFS_TMR |-> pslverr)
    else $error("unmapped access without error");
  unmapped_zero_a: assert property (psel && penable && paddr > OFS_TMR |-> prdata == '0)
    else $error("unmapped read not zero");
  cover property (psel && penable && paddr == OFS_CMD);
  cover property ($fell(rf_gate));
  cover property (pin_ovt_shutdown && !rf_gate);
endmodule // rpg_gate_checker
bind rpg_gate rpg_gate_checker rpg_gate_checker_i (.ref_clk, .rst_n, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .pin_ovt_shutdown, .pin_interlock_ok, .pin_mains_ok, .rf_gate, .leds);

// ==== rpg_host_model.sv ====
// Purpose: Host side issuing serial commands over APB
// Assumes: Zero or more wait states
// Notes: Data bus inverted when released
module rpg_host_model
  import rpg_pkg::*;
(
  input wire logic ref_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] r;
  logic e;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // ==========================================
  // Transfers
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] arg);
    xfer(1'b1, OFS_CMD, {8'h00, arg, c}, r, e);
  endtask
  task automatic set_pulse(input logic [15:0] f, input logic [7:0] d);
    cmd(CMD_OFF, 16'h0);
    cmd(CMD_SET_FREQ, f);
    cmd(CMD_SET_DUTY, {8'h00, d});
  endtask
  task automatic clear_fault();
    cmd(CMD_OFF, 16'h0);
  endtask
endmodule // rpg_host_model

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the pulse gate
// Assumes: Seeded random settings with corner cases
// Notes: Indicator blink too slow to observe here
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rpg_pkg::*;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, rf_gate, e;
  logic ovt_sd, ovt_warn, ilock_ok, mains_ok, at_sp, umode_in, on_req, off_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  rpg_led_s leds;
  int miscompares, num_checks, cyc, f, d, cnt;
  int ft[6] = '{150, 50000, 149, 50001, 1000, 1000};
  int dt[6] = '{10, 90, 50, 50, 9, 91};
  rpg_host_model rpg_host_model_i (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  rpg_gate rpg_gate_i (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .user_mode(umode_in), .output_enable_request(on_req),
    .output_disable_request(off_req), .pin_ovt_shutdown(ovt_sd), .pin_ovt_warning(ovt_warn),
    .pin_interlock_ok(ilock_ok), .pin_mains_ok(mains_ok), .pin_at_setpoint(at_sp), .rf_gate,
    .leds);
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    rpg_host_model_i.xfer(1'b0, a, 32'h0, v, e);
  endtask
  task automatic rb(input logic [7:0] c);
    rpg_host_model_i.cmd(c, 16'h0);
    rd(OFS_RESP);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  function automatic logic ok(input int f, input int d);
    return f >= FREQ_MIN && f <= FREQ_MAX && d >= DUTY_MIN && d <= DUTY_MAX;
  endfunction
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========================================
  // Scenarios
  initial
  begin
    {rst_n, ovt_sd, ovt_warn, at_sp} = 4'b0001;
    {ilock_ok, mains_ok} = 2'b11;
    {umode_in, on_req, off_req} = 3'b000;
    void'($urandom(32'h3c45));
    wt(10);
    rst_n <= 1'b1;
    wt(4);
    for (int i = 0; i < 10; i++)
    begin
      f = (i < 6) ? ft[i] : 150 + $urandom % 49851;
      d = (i < 6) ? dt[i] : 10 + $urandom % 81;
      rpg_host_model_i.set_pulse(f[15:0], d[7:0]);
      rd(OFS_STAT);
      chk(v[7], ok(f, d));
      if (ok(f, d))
      begin
        rb(CMD_GET_FREQ);
        chk(v, f);
        rb(CMD_GET_DUTY);
        chk(v, d);
      end
    end
    d = 10 + $urandom % 81;
    rpg_host_model_i.set_pulse(16'd50000, d[7:0]);
    rpg_host_model_i.cmd(CMD_ON, 16'h0);
    for (cnt = 0; cnt < 3000 && rf_gate !== 1'b1; cnt++) @(negedge ref_clk);
    cnt = 0;
    repeat (CLK_HZ / 50000) @(negedge ref_clk) cnt += (rf_gate === 1'b1);
    f = CLK_HZ / 50000 * d / 100;
    chk(cnt >= f - 2 && cnt <= f + 2, 1'b1);
    rpg_host_model_i.cmd(CMD_SET_FREQ, 16'd300);
    rb(CMD_GET_FREQ);
    chk(v, 50000);
    rpg_host_model_i.set_pulse(16'd1000, 8'd95);
    rpg_host_model_i.xfer(1'b1, OFS_TMR, 32'd30, v, e);
    rd(OFS_TMR);
    chk(v, 32'd30);
    at_sp <= 1'b0;
    rpg_host_model_i.cmd(CMD_ON, 16'h0);
    wt(4);
    chk({rf_gate, leds.output_on}, 2'b11);
    wt(100);
    chk(rf_gate, 1'b0);
    rd(OFS_ERR);
    chk(v, ERR_TIMER);
    at_sp <= 1'b1;
    rpg_host_model_i.xfer(1'b1, OFS_TMR, 32'd0, v, e);
    rpg_host_model_i.cmd(CMD_OFF, 16'h0);
    rd(OFS_ERR);
    chk(v, ERR_NONE);
    rpg_host_model_i.cmd(CMD_ON, 16'h0);
    ovt_warn <= 1'b1;
    wt(8);
    chk({rf_gate, leds.alarm}, 2'b10);
    ovt_sd <= 1'b1;
    wt(8);
    chk({rf_gate, leds.ovt, leds.alarm}, 3'b011);
    rd(OFS_ERR);
    chk(v, ERR_OTEMP);
    ovt_sd <= 1'b0;
    wt(8);
    chk({rf_gate, leds.ovt, leds.alarm}, 3'b011);
    ovt_warn <= 1'b0;
    wt(4);
    rpg_host_model_i.cmd(CMD_OFF, 16'h0);
    wt(4);
    chk({leds.alarm, leds.output_on}, 2'b00);
    rpg_host_model_i.cmd(CMD_ON, 16'h0);
    ilock_ok <= 1'b0;
    wt(8);
    chk({rf_gate, leds.ilock}, 2'b00);
    rpg_host_model_i.cmd(CMD_OFF, 16'h0);
    wt(4);
    chk(leds.ilock, 1'b0);
    ilock_ok <= 1'b1;
    wt(8);
    rpg_host_model_i.cmd(CMD_ON, 16'h0);
    wt(4);
    chk({rf_gate, leds.ilock}, 2'b00);
    rpg_host_model_i.cmd(CMD_OFF, 16'h0);
    rpg_host_model_i.cmd(CMD_ON, 16'h0);
    wt(4);
    chk({rf_gate, leds.ilock}, 2'b11);
    mains_ok <= 1'b0;
    wt(8);
    chk({rf_gate, leds.alarm, leds.mains_present_indicator}, 3'b010);
    rd(OFS_ERR);
    chk(v, ERR_SUPPLY);
    mains_ok <= 1'b1;
    wt(4);
    rpg_host_model_i.clear_fault();
    wt(4);
    chk(leds.alarm, 1'b0);
    rd(8'h40);
    chk({e, v[30:0]}, 32'h80000000);
    rpg_host_model_i.set_pulse(16'd2000, 8'd30);
    {umode_in, on_req} <= 2'b11;
    rst_n <= 1'b0;
    wt(10);
    rst_n <= 1'b1;
    wt(4);
    rb(CMD_GET_FREQ);
    chk(v, FREQ_RST);
    rb(CMD_GET_DUTY);
    chk(v, DUTY_RST);
    rd(OFS_STAT);
    chk({rf_gate, v[7:6]}, 3'b001);
    {on_req, off_req} <= 2'b01;
    wt(6);
    rd(OFS_STAT);
    chk(v[6], 1'b0);
    {on_req, off_req} <= 2'b10;
    wt(8);
    chk(rf_gate, 1'b1);
    {on_req, off_req} <= 2'b01;
    wt(8);
    chk(rf_gate, 1'b0);
    give_verdict();
  end
endmodule // tb_top
